// file: test/icc_monitor.sv
// Port checker for the capture block, bound onto icc_top.
`include "icc_defines.vh"
module icc_monitor #(
  parameter NCH = 4
) (
  // Clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // APB
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [15:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Pins, power state, events
  input wire logic [NCH-1:0] capture_pin,
  input wire logic           cpu_idle,
  input wire logic           cpu_sleep,
  input wire logic [NCH-1:0] capture_event_flag,
  input wire logic [NCH-1:0] wake_request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_reg;
  logic       ie_reg;
  logic       clean_reg;
  logic       wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  // Shadow of channel one's mode and enable; ports hide the registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 3'h0;
      ie_reg <= 1'b0;
      clean_reg <= 1'b0;
    end else if (wr_done && paddr[13:2] == `ICC_IDX_CON1) begin
      mode_reg <= pwdata[2:0];
      clean_reg <= pwdata[2:0] == `ICC_M_BOTH && !pwdata[4];
    end else if (wr_done && paddr[13:2] == `ICC_IDX_FLAGS) begin
      ie_reg <= pwdata[8];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no answer");
  property p_err_zero;
    pslverr |-> pready && (pwrite || prdata == 32'h0);
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error read");
  property p_both_flag;
    mode_reg == `ICC_M_BOTH && $changed(capture_pin[0]) && !cpu_sleep
      && !cpu_idle |-> ##3 capture_event_flag[0];
  endproperty
  a_both_flag: assert property (p_both_flag)
    else $error("edge gave no event");
  property p_both_no_ov;
    pready && !pwrite && paddr[13:2] == `ICC_IDX_CON1 && clean_reg
      |-> !prdata[4];
  endproperty
  a_both_no_ov: assert property (p_both_no_ov)
    else $error("overflow in both-edge mode");
  property p_wake_cause;
    wake_request[0] |-> capture_event_flag[0] && $past(ie_reg)
      && ($past(cpu_idle) || $past(cpu_sleep));
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake without cause");
  property p_sleep_wake;
    cpu_sleep && ie_reg && mode_reg == `ICC_M_INT && $rose(capture_pin[0])
      |-> ##3 capture_event_flag[0] && wake_request[0];
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("no wake from sleep");
  property p_sleep_prescale;
    cpu_sleep && $past(cpu_sleep) && $past(cpu_sleep, 2)
      && mode_reg[2:1] == 2'b10 |-> !$rose(capture_event_flag[0]);
  endproperty
  a_sleep_prescale: assert property (p_sleep_prescale)
    else $error("prescaled event in sleep");
endmodule // icc_monitor

bind icc_top icc_monitor #(.NCH(NCH)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
  .capture_event_flag(capture_event_flag), .wake_request(wake_request)
);

// file: test/icc_pin_model.sv
// Edge source model standing in for the signal on the capture pins.
module icc_pin_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pulse request from the bench
  input  wire logic       go,
  input  wire logic [1:0] chan,
  input  wire logic [3:0] hi_len,
  // Pin levels, resting low between pulses
  output logic      [3:0] capture_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_reg;
  // Raise the chosen pin for hi_len cycles, one pulse at a time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_pin <= 4'h0;
      left_reg <= 4'h0;
    end else if (go) begin
      capture_pin[chan] <= 1'b1;
      left_reg <= hi_len;
    end else if (left_reg == 4'h1) begin
      capture_pin <= 4'h0;
      left_reg <= 4'h0;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end
  end
endmodule // icc_pin_model

// file: test/tb_top.sv
// Self-checking bench for the four-channel capture block.
`include "icc_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] CON_I [4] = '{`ICC_IDX_CON1, `ICC_IDX_CON2,
                                        `ICC_IDX_CON7, `ICC_IDX_CON8};
  localparam logic [11:0] BUF_I [4] = '{`ICC_IDX_BUF1, `ICC_IDX_BUF2,
                                        `ICC_IDX_BUF7, `ICC_IDX_BUF8};
  localparam logic [2:0]  MODES [4] = '{`ICC_M_FALL, `ICC_M_R4,
                                        `ICC_M_R16, `ICC_M_BOTH};
  localparam int          CNT [4]   = '{3, 6, 16, 3};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        go, run1, run2, cpu_idle, cpu_sleep, err, ovx;
  logic [1:0]  chan;
  logic [3:0]  hi_len, pins, flags, wake;
  logic [15:0] paddr, tb_t, cw, q[$];
  logic [31:0] pwdata, prdata, rd;
  integer      seed;
  int          fails, comparisons, cycles, wakes, rises, i, m, k;
  icc_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin(pins),
    .first_time_base(tb_t), .second_time_base(tb_t ^ 16'hA5A5),
    .first_base_running(run1), .second_base_running(run2),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .capture_event_flag(flags), .wake_request(wake)
  );
  icc_pin_model pin_u (
    .pclk(pclk), .presetn(presetn), .go(go), .chan(chan),
    .hi_len(hi_len), .capture_pin(pins)
  );
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Free-running time base and watchdog; a hang ends in the same report
  always @(posedge pclk) begin
    tb_t <= tb_t + 16'h1;
    cycles++;
    if (wake[0] === 1'b1) wakes++;
    if (cycles == 20000) begin
      fails++;
      final_report;
    end
  end
  function automatic logic [15:0] addr(input logic [11:0] x);
    return {2'b0, x, 2'b0};
  endfunction
  function automatic logic [15:0] stamp(input logic [15:0] v);
    return cw[7] ? v : v ^ 16'hA5A5;
  endfunction
  // Book a capture the way the buffer should take or refuse it
  function automatic void book(input logic [15:0] v);
    logic sel;
    sel = cw[7] ? run1 : run2;
    if (cpu_sleep || (cpu_idle && (!sel || cw[13]))) return;
    if (q.size() == 4) begin
      if (cw[2:0] != `ICC_M_BOTH) ovx = 1'b1;
    end else if (!(ovx && q.size() != 0)) begin
      q.push_back(v);
    end
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Mode 000 first so the prescaler and interval counts restart
  task automatic cfg(input int ch, input logic [15:0] w);
    apb(1'b1, addr(CON_I[ch]), 32'h0);
    apb(1'b1, addr(CON_I[ch]), {16'h0, w});
    cw = w;
    rises = 0;
    ovx = 1'b0;
  endtask
  // Pin pulse; capture lands one edge after the synchronised edge
  task automatic pulse(input int ch, input logic [3:0] len);
    logic [15:0] r;
    logic [15:0] f;
    go <= 1'b1;
    chan <= ch[1:0];
    hi_len <= len;
    @(posedge pclk);
    go <= 1'b0;
    #1;
    r = stamp(tb_t + 16'h2);
    f = stamp(tb_t + 16'h2 + {12'h0, len});
    rises++;
    case (cw[2:0])
      `ICC_M_FALL: book(f);
      `ICC_M_RISE: book(r);
      `ICC_M_R4: if (rises % 4 == 0) book(r);
      `ICC_M_R16: if (rises % 16 == 0) book(r);
      `ICC_M_BOTH: begin
        book(r);
        book(f);
      end
      default: ;
    endcase
    repeat (len + 6) @(posedge pclk);
  endtask
  // Status first, then n buffer reads against the booked order
  task automatic drain(input int ch, input int n);
    apb(1'b0, addr(CON_I[ch]), 32'h0);
    chk(rd & 32'h18, {27'h0, ovx, q.size() != 0, 3'h0});
    repeat (n) begin
      apb(1'b0, addr(BUF_I[ch]), 32'h0);
      chk(rd, {16'h0, q.pop_front()});
    end
  endtask
  task automatic flag_chk(input logic e);
    apb(1'b0, addr(`ICC_IDX_FLAGS), 32'h0);
    chk(rd & 32'h1, {31'h0, e});
  endtask
  initial begin
    seed = 32'h72042763;
    presetn = 1'b0;
    {psel, penable, pwrite, go, cpu_idle, cpu_sleep, ovx} = 7'h0;
    {run1, run2} = 2'h3;
    {paddr, pwdata, chan, hi_len, cw} = 0;
    tb_t = 16'($random(seed));
    {fails, comparisons, cycles, wakes, rises} = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, addr(CON_I[0]), 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h0600, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    for (i = 0; i < 4; i++) begin
      cfg(i, {8'h0, i[0], 4'h0, `ICC_M_RISE});
      pulse(i, 4'h2);
      drain(i, 1);
      chk({28'h0, flags}, 32'((1 << (i + 1)) - 1));
    end
    // Edge modes with random widths; the 16th-rise run catches a stale count
    for (m = 0; m < 4; m++) begin
      cfg(0, {13'h0, MODES[m]});
      repeat (CNT[m]) pulse(0, 4'h1 + 4'($random(seed) & 3));
      drain(0, q.size());
      drain(0, 0);
    end
    cfg(0, {13'h0, `ICC_M_RISE});
    repeat (5) pulse(0, 4'h3);
    drain(0, 2);
    pulse(0, 4'h2);
    drain(0, 2);
    pulse(0, 4'h2);
    drain(0, 1);
    drain(0, 0);
    cfg(0, 16'h0020 | `ICC_M_RISE);
    apb(1'b1, addr(`ICC_IDX_FLAGS), 32'hF);
    pulse(0, 4'h2);
    flag_chk(1'b0);
    pulse(0, 4'h2);
    flag_chk(1'b1);
    drain(0, 2);
    cfg(0, 16'h0060 | `ICC_M_BOTH);
    apb(1'b1, addr(`ICC_IDX_FLAGS), 32'hF);
    pulse(0, 4'h2);
    flag_chk(1'b1);
    drain(0, 2);
    // Asleep, only mode 111 flags and wakes; nothing is buffered
    apb(1'b1, addr(`ICC_IDX_FLAGS), 32'h10F);
    cfg(0, {13'h0, `ICC_M_INT});
    cpu_sleep <= 1'b1;
    k = wakes;
    pulse(0, 4'h2);
    flag_chk(1'b1);
    chk(32'(wakes - k), 32'h1);
    drain(0, 0);
    cfg(0, {13'h0, `ICC_M_R4});
    apb(1'b1, addr(`ICC_IDX_FLAGS), 32'h10F);
    repeat (4) pulse(0, 4'h1);
    flag_chk(1'b0);
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    run2 <= 1'b0;
    cfg(0, {13'h0, `ICC_M_RISE});
    pulse(0, 4'h2);
    run2 <= 1'b1;
    pulse(0, 4'h2);
    drain(0, 1);
    cfg(0, 16'h2000 | `ICC_M_RISE);
    pulse(0, 4'h2);
    drain(0, 0);
    cpu_idle <= 1'b0;
    final_report;
  end
endmodule // tb_top

// file: verilog/icc_defines.vh
// Constants for the four-channel input capture block.
//-----------------------------------------------------------------------------
// Behaviour
// - Capture on falling, rising, every 4th rising, 16th rising or both edges.
// - Edge prescaler counter clears when channel is off and on reset.
// - Each channel buffers captures in a four-entry, 16-bit FIFO.
// - Not-empty flag sets on first capture, stays until all entries read.
// - A buffer read returns the oldest entry and advances the rest.
// - Fifth capture into a full buffer sets overflow; value is dropped.
// - After overflow, nothing is stored until all four entries are read.
// - Reading an empty buffer returns an undefined value.
// - Control bit 7 picks the time base; second time base after reset.
// - Mode 001 sets the event flag on every rising and falling edge.
// - Mode 001 ignores the interrupt interval field.
// - Mode 001 never reports capture overflow.
// - In Idle or Sleep an enabled event requests wake-up or interrupt.
// - Mode 111 with enable wakes from Sleep or Idle, timer running or not.
// - In Sleep the channel is only an interrupt source; interval ignored.
// - In Sleep the divide-by-4 and divide-by-16 settings do nothing.
// - Four independent channels, numbered one, two, seven and eight.
// - Two-bit interval field at control bits 6:5 sets captures per event.
// - Full capture in Idle only with timer enabled and idle-stop clear.
// - In Idle with mode 111 the pin is only an interrupt input.
//-----------------------------------------------------------------------------
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH

// Register indices; byte address is four times the index
`define ICC_IDX_BUF1  12'h140
`define ICC_IDX_CON1  12'h142
`define ICC_IDX_BUF2  12'h144
`define ICC_IDX_CON2  12'h146
`define ICC_IDX_BUF7  12'h158
`define ICC_IDX_CON7  12'h15A
`define ICC_IDX_BUF8  12'h15C
`define ICC_IDX_CON8  12'h15E
`define ICC_IDX_FLAGS 12'h160

// Control register fields
`define ICC_MODE_HI   2
`define ICC_MODE_LO   0
`define ICC_BNE_BIT   3
`define ICC_OV_BIT    4
`define ICC_ICI_HI    6
`define ICC_ICI_LO    5
`define ICC_TSEL_BIT  7
`define ICC_SIDL_BIT  13

// Flag register fields
`define ICC_FLG_LO    0
`define ICC_IE_LO     8

// Capture mode codes
`define ICC_M_OFF     3'h0
`define ICC_M_BOTH    3'h1
`define ICC_M_FALL    3'h2
`define ICC_M_RISE    3'h3
`define ICC_M_R4      3'h4
`define ICC_M_R16     3'h5
`define ICC_M_INT     3'h7

// Prescaler terminal counts
`define ICC_PRE4_LAST  4'h3
`define ICC_PRE16_LAST 4'hF

`endif

// file: verilog/icc_edge_sync.v
// Pin synchroniser and edge detector for one capture input.
module icc_edge_sync (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Pin and edge pulses
  input  wire pin,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // Two-stage synchroniser; only the second stage feeds the detector
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // One-cycle edge pulses
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule // icc_edge_sync

// file: verilog/icc_fifo.v
// Shifting capture FIFO: head is the oldest entry whenever the FIFO is not empty.
module icc_fifo #(
  parameter W  = 16,
  parameter D  = 4,
  parameter CW = 3
) (
  // Clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // Fill and drain
  input  wire          push,
  input  wire          pop,
  input  wire [W-1:0]  din,
  output wire [W-1:0]  head,
  output wire [CW-1:0] count,
  output wire          full
);

  localparam integer  DI    = D;
  localparam [CW-1:0] FULLC = DI[CW-1:0];
  localparam [CW-1:0] ONE   = {{(CW-1){1'b0}}, 1'b1};

  reg [W-1:0]  slot_reg [0:D-1];
  reg [CW-1:0] cnt_reg;

  // Pop on empty is ignored, so a stale head is returned
  wire          do_pop  = pop & (cnt_reg != {CW{1'b0}});
  wire          do_push = push & (~full | do_pop);
  wire [CW-1:0] wpos    = do_pop ? cnt_reg - ONE : cnt_reg;

  // Occupancy counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_reg <= {CW{1'b0}};
    else if (do_push & ~do_pop)
      cnt_reg <= cnt_reg + ONE;
    else if (do_pop & ~do_push)
      cnt_reg <= cnt_reg - ONE;
  end

  // Each slot loads new data; all but the last take their neighbour on a read
  genvar i;
  generate
    for (i = 0; i < D; i = i + 1) begin : slot
      localparam integer  PI  = i;
      localparam [CW-1:0] POS = PI[CW-1:0];
      if (i < D - 1) begin : mid
        always @(posedge pclk or negedge presetn) begin
          if (!presetn)
            slot_reg[i] <= {W{1'b0}};
          else if (do_push && wpos == POS)
            slot_reg[i] <= din;
          else if (do_pop)
            slot_reg[i] <= slot_reg[i+1];
        end
      end else begin : last
        always @(posedge pclk or negedge presetn) begin
          if (!presetn)
            slot_reg[i] <= {W{1'b0}};
          else if (do_push && wpos == POS)
            slot_reg[i] <= din;
        end
      end
    end
  endgenerate

  assign head  = slot_reg[0];
  assign count = cnt_reg;
  assign full  = (cnt_reg == FULLC);

endmodule // icc_fifo

// file: verilog/icc_top.v
// Four-channel input capture block with an APB register slave.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`include "icc_defines.vh"

module icc_top #(
  parameter NCH   = 4,
  parameter DW    = 16,
  parameter DEPTH = 4,
  parameter CW    = 3
) (
  // APB clock and reset
  input  wire            pclk,
  input  wire            presetn,
  // APB slave
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [15:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  // Capture pins, index 0..3 for channels one, two, seven, eight
  input  wire [NCH-1:0]  capture_pin,
  // Time bases and their run state
  input  wire [DW-1:0]   first_time_base,
  input  wire [DW-1:0]   second_time_base,
  input  wire            first_base_running,
  input  wire            second_base_running,
  // Processor power state
  input  wire            cpu_idle,
  input  wire            cpu_sleep,
  // Event flags and wake requests
  output wire [NCH-1:0]  capture_event_flag,
  output wire [NCH-1:0]  wake_request
);

  //---------------------------------------------------------------------------
  // Bus decode
  //---------------------------------------------------------------------------

  wire [11:0] idx = paddr[13:2];

  // First access cycle; the answer follows one cycle later
  wire acc_first = psel & penable & ~pready;
  // Completing edge: writes and buffer pops take effect only here
  wire acc_done  = psel & penable & pready;
  wire wr_done   = acc_done & pwrite;
  wire rd_done   = acc_done & ~pwrite;

  // Per-channel hits and readback
  wire [NCH-1:0]    hit_buf;
  wire [NCH-1:0]    hit_con;
  wire [NCH*DW-1:0] buf_all;
  wire [NCH*DW-1:0] con_all;
  wire [NCH-1:0]    flag_all;
  wire [NCH-1:0]    wake_all;
  wire              hit_flags = (idx == `ICC_IDX_FLAGS);

  // Channel interrupt enables, software owned
  reg [NCH-1:0] ie_reg;

  //---------------------------------------------------------------------------
  // Enable register
  //---------------------------------------------------------------------------

  // Enables share the flag register with the sticky flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ie_reg <= {NCH{1'b0}};
    else if (wr_done && hit_flags)
      ie_reg <= pwdata[`ICC_IE_LO +: NCH];
  end

  //---------------------------------------------------------------------------
  // Channels
  //---------------------------------------------------------------------------

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      localparam [11:0] BIDX = (g == 0) ? `ICC_IDX_BUF1 :
                               (g == 1) ? `ICC_IDX_BUF2 :
                               (g == 2) ? `ICC_IDX_BUF7 : `ICC_IDX_BUF8;
      localparam [11:0] CIDX = (g == 0) ? `ICC_IDX_CON1 :
                               (g == 1) ? `ICC_IDX_CON2 :
                               (g == 2) ? `ICC_IDX_CON7 : `ICC_IDX_CON8;

      wire          rise;
      wire          fall;
      wire [DW-1:0] head;
      wire [CW-1:0] cnt;
      wire          full;

      reg [2:0] mode_reg;
      reg [1:0] ici_reg;
      reg       tsel_reg;
      reg       sidl_reg;
      reg       ov_reg;
      reg [3:0] pre_reg;
      reg [1:0] icnt_reg;
      reg       flag_reg;
      reg       wake_reg;
      reg       ev;

      // Pin conditioning
      icc_edge_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (capture_pin[g]),
        .rise    (rise),
        .fall    (fall)
      );

      assign hit_buf[g] = (idx == BIDX);
      assign hit_con[g] = (idx == CIDX);

      wire con_wr = wr_done & hit_con[g];
      wire buf_rd = rd_done & hit_buf[g];

      // Time base choice; clear bit means the second base
      wire          t_run = tsel_reg ? first_base_running
                                     : second_base_running;
      wire [DW-1:0] t_val = tsel_reg ? first_time_base
                                     : second_time_base;

      // Full operation: awake, or idle with timer running and idle-stop clear
      wire full_op  = ~cpu_sleep & (~cpu_idle | (t_run & ~sidl_reg));
      wire int_only = (mode_reg == `ICC_M_INT);
      wire both     = (mode_reg == `ICC_M_BOTH);
      wire pre_mode = (mode_reg == `ICC_M_R4) | (mode_reg == `ICC_M_R16);
      wire pre_hit  = (mode_reg == `ICC_M_R4) ?
                      (pre_reg == `ICC_PRE4_LAST) :
                      (pre_reg == `ICC_PRE16_LAST);

      // Edge selection per mode; unused code 110 captures nothing
      always @* begin
        case (mode_reg)
          `ICC_M_BOTH: ev = rise | fall;
          `ICC_M_FALL: ev = fall;
          `ICC_M_RISE: ev = rise;
          `ICC_M_R4:   ev = rise & pre_hit;
          `ICC_M_R16:  ev = rise & pre_hit;
          default:     ev = 1'b0;
        endcase
      end

      // Captures happen only in full operation
      wire cap    = ev & full_op;
      // Storage stays blocked after overflow until drained
      wire block  = ov_reg & (cnt != {CW{1'b0}});
      wire push   = cap & ~full & ~block;
      // Both-edge mode drops silently instead of flagging
      wire ov_set = cap & full & ~both;

      // Mode 111 raises events on rising edges in any state
      // Both-edge mode and Sleep ignore the interval
      wire int_ev = int_only ? rise
                  : cap & (both | (icnt_reg == ici_reg));

      // Control fields; reset selects the second time base
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_reg <= `ICC_M_OFF;
          ici_reg  <= 2'h0;
          tsel_reg <= 1'b0;
          sidl_reg <= 1'b0;
        end else if (con_wr) begin
          mode_reg <= pwdata[`ICC_MODE_HI:`ICC_MODE_LO];
          ici_reg  <= pwdata[`ICC_ICI_HI:`ICC_ICI_LO];
          tsel_reg <= pwdata[`ICC_TSEL_BIT];
          sidl_reg <= pwdata[`ICC_SIDL_BIT];
        end
      end

      // Overflow: writing zero clears it, a new overflow wins
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          ov_reg <= 1'b0;
        else if (ov_set)
          ov_reg <= 1'b1;
        else if (con_wr && !pwdata[`ICC_OV_BIT])
          ov_reg <= 1'b0;
      end

      // Edge prescaler; frozen in Sleep where it must not act
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pre_reg <= 4'h0;
        else if (mode_reg == `ICC_M_OFF)
          pre_reg <= 4'h0;
        else if (rise && pre_mode && !cpu_sleep)
          pre_reg <= pre_hit ? 4'h0 : pre_reg + 4'h1;
      end

      // Interval counter, counts captures between events
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          icnt_reg <= 2'h0;
        else if (mode_reg == `ICC_M_OFF)
          icnt_reg <= 2'h0;
        else if (cap && !both)
          icnt_reg <= (icnt_reg == ici_reg) ? 2'h0 : icnt_reg + 2'h1;
      end

      // Sticky event flag: write one to clear, a new event wins
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          flag_reg <= 1'b0;
        else if (int_ev)
          flag_reg <= 1'b1;
        else if (wr_done && hit_flags && pwdata[`ICC_FLG_LO + g])
          flag_reg <= 1'b0;
      end

      // Wake pulse for an enabled event in Idle or Sleep
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          wake_reg <= 1'b0;
        else
          wake_reg <= int_ev & ie_reg[g] & (cpu_idle | cpu_sleep);
      end

      // Capture buffer, popped by a completed buffer read
      icc_fifo #(
        .W  (DW),
        .D  (DEPTH),
        .CW (CW)
      ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .push    (push),
        .pop     (buf_rd),
        .din     (t_val),
        .head    (head),
        .count   (cnt),
        .full    (full)
      );

      // Readback images; not-empty follows occupancy
      assign buf_all[g*DW +: DW] = head;
      assign con_all[g*DW +: DW] = {2'h0, sidl_reg, 5'h00, tsel_reg,
                                    ici_reg, ov_reg,
                                    (cnt != {CW{1'b0}}), mode_reg};
      assign flag_all[g] = flag_reg;
      assign wake_all[g] = wake_reg;
    end
  endgenerate

  //---------------------------------------------------------------------------
  // Read multiplexer
  //---------------------------------------------------------------------------

  reg [31:0] rd_val;
  reg        rd_hit;
  integer    k;

  // Unmapped addresses read zero and answer with an error
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = hit_flags;
    if (hit_flags) begin
      rd_val[`ICC_FLG_LO +: NCH] = flag_all;
      rd_val[`ICC_IE_LO +: NCH]  = ie_reg;
    end
    for (k = 0; k < NCH; k = k + 1) begin
      if (hit_buf[k]) begin
        rd_val[DW-1:0] = buf_all[k*DW +: DW];
        rd_hit = 1'b1;
      end
      if (hit_con[k]) begin
        rd_val[DW-1:0] = con_all[k*DW +: DW];
        rd_hit = 1'b1;
      end
    end
  end

  //---------------------------------------------------------------------------
  // APB answer
  //---------------------------------------------------------------------------

  // One wait state keeps every bus output registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~rd_hit;
      if (acc_first && !pwrite)
        prdata <= rd_val;
    end
  end

  assign capture_event_flag = flag_all;
  assign wake_request       = wake_all;

endmodule // icc_top
